// file: design/chan_dma_ctrl.v
// channel register port, transmit control and receive launcher
//
// Notes on behaviour
// - tx count reads transmit chain words, zero-extended
// - tx chain: two 511-word fifos plus up to 8M memory words
// - rx count reads chain words plus pipeline, zero-extended
// - pointer write launches fetch of three long words
// - descriptor: buffer, length, next; stop at end-of-chain
// - writing zero to the pointer aborts the transfer
// - descriptor addresses are used as bus master addresses
// - port write pushes transmit, read pops receive
// - tx low flag when count below 16-bit level
// - rx high flag when count at or above 16-bit level
// - tx control: drain 9, fill 8, select 6, 3, 2, run 0
// - run starts sending once data suffices; clear forces idle
// - done enable interrupts when transmitter empties and idles
// - low enable interrupts from tx low flag
// - fill: dma fifo to memory; drain: memory to io fifo
// - transmitter waits for hold-off bytes in io fifo; zero none
// - io fifo holds at most 2044 bytes; larger hold-off never met
// - high enable interrupts from rx high flag
// - rx write while full sets overrun; enabled overrun interrupts
`timescale 1ns/100ps
`include "chan_dma_regs.vh"
module chan_dma_ctrl (
    input wire clock_i,
    input wire rst_i,
    input wire [7:0] reg_addr_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [31:0] reg_wdata_i,
    output reg [31:0] reg_rdata_o,
    output reg reg_rvalid_o,
    output wire mst_req_o,
    output wire mst_we_o,
    output wire [31:0] mst_addr_o,
    output wire [31:0] mst_wdata_o,
    input wire mst_ack_i,
    input wire [31:0] mst_rdata_i,
    input wire mst_err_i,
    input wire [23:0] tx_chain_count_i,
    input wire [23:0] rx_chain_count_i,
    input wire [11:0] tx_io_bytes_i,
    output reg tx_push_o,
    output reg [31:0] tx_push_data_o,
    input wire rx_empty_i,
    input wire [31:0] rx_data_i,
    output wire rx_pop_o,
    input wire rx_full_i,
    input wire rx_write_i,
    input wire overrun_clear_i,
    output wire tx_memory_fill_enable_o,
    output wire tx_memory_drain_enable_o,
    output wire rx_memory_fill_enable_o,
    output wire rx_memory_drain_enable_o,
    output wire rx_run_o,
    input wire link_clk_i,
    output reg tx_byte_pop_o,
    output reg tx_active_o,
    output wire tx_idle_o,
    output wire tx_low_o,
    output wire rx_high_o,
    output reg rx_overrun_o,
    output wire dma_busy_o,
    output reg dma_done_o,
    output wire dma_err_o,
    output reg irq_o
);
    localparam T_IDLE = 2'b00;
    localparam T_WAIT = 2'b01;
    localparam T_SEND = 2'b10;

    reg [31:0] tx_control_q;
    reg [31:0] rx_control_q;
    reg [15:0] tx_low_threshold_q;
    reg [15:0] rx_high_threshold_q;
    reg [31:0] tx_start_holdoff_q;
    reg [1:0] tx_state_q;
    reg tx_done_q;
    reg link_meta_q;
    reg link_sync_q;
    reg link_prev_q;
    reg port_pop_q;
    reg walk_start_q;
    reg [31:0] walk_ptr_q;
    wire walk_pop;
    wire walk_done;
    wire link_fall;
    wire start_ok;
    wire wr_hit_ptr;

    function hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    function [31:0] zext;
        input [23:0] cnt;
        begin
            zext = {8'h00, cnt};
        end
    endfunction

    // ********
    // register writes
    // ********
    assign wr_hit_ptr = reg_wr_i && hit(reg_addr_i, `OFS_RX_DESC_START);

    always @(posedge clock_i) begin
        if (rst_i) begin
            tx_control_q <= `RST_ZERO;
            rx_control_q <= `RST_ZERO;
            tx_low_threshold_q <= 16'h0000;
            rx_high_threshold_q <= 16'h0000;
            tx_start_holdoff_q <= `RST_ZERO;
            tx_push_o <= 1'b0;
            tx_push_data_o <= `RST_ZERO;
            walk_start_q <= 1'b0;
            walk_ptr_q <= `RST_ZERO;
        end else begin
            tx_push_o <= 1'b0;
            walk_start_q <= 1'b0;
            if (reg_wr_i) begin
                if (hit(reg_addr_i, `OFS_TX_CONTROL))
                    tx_control_q <= reg_wdata_i & `CTRL_MASK;
                if (hit(reg_addr_i, `OFS_RX_CONTROL))
                    rx_control_q <= reg_wdata_i & `RX_CTRL_MASK;
                if (hit(reg_addr_i, `OFS_TX_LOW_THRESHOLD))
                    tx_low_threshold_q <= reg_wdata_i[15:0];
                if (hit(reg_addr_i, `OFS_RX_HIGH_THRESHOLD))
                    rx_high_threshold_q <= reg_wdata_i[15:0];
                if (hit(reg_addr_i, `OFS_TX_START_HOLDOFF))
                    tx_start_holdoff_q <= reg_wdata_i;
                if (hit(reg_addr_i, `OFS_FIFO_PORT)) begin
                    tx_push_o <= 1'b1;
                    tx_push_data_o <= reg_wdata_i;
                end
            end
            if (wr_hit_ptr) begin
                walk_start_q <= 1'b1;
                walk_ptr_q <= reg_wdata_i;
            end
        end
    end

    // ********
    // register reads, one cycle after the strobe
    // ********
    always @(posedge clock_i) begin
        if (rst_i) begin
            reg_rdata_o <= `RST_ZERO;
            reg_rvalid_o <= 1'b0;
            port_pop_q <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            port_pop_q <= 1'b0;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `OFS_TX_WORD_COUNT:
                        reg_rdata_o <= zext(tx_chain_count_i);
                    `OFS_RX_WORD_COUNT:
                        reg_rdata_o <= zext(rx_chain_count_i);
                    `OFS_FIFO_PORT: begin
                        reg_rdata_o <= rx_data_i;
                        port_pop_q <= !rx_empty_i && !walk_pop;
                    end
                    `OFS_TX_LOW_THRESHOLD:
                        reg_rdata_o <= {16'h0000, tx_low_threshold_q};
                    `OFS_RX_HIGH_THRESHOLD:
                        reg_rdata_o <= {16'h0000, rx_high_threshold_q};
                    `OFS_TX_CONTROL: reg_rdata_o <= tx_control_q;
                    `OFS_RX_CONTROL: reg_rdata_o <= rx_control_q;
                    `OFS_TX_START_HOLDOFF:
                        reg_rdata_o <= tx_start_holdoff_q;
                    default: reg_rdata_o <= `RST_ZERO;
                endcase
            end
        end
    end

    // ********
    // fifo port pop and memory controller enables
    // ********
    assign rx_pop_o = port_pop_q | walk_pop;
    assign tx_memory_fill_enable_o = tx_control_q[`BIT_FILL_EN];
    assign tx_memory_drain_enable_o = tx_control_q[`BIT_DRAIN_EN];
    assign rx_memory_fill_enable_o = rx_control_q[`BIT_FILL_EN];
    assign rx_memory_drain_enable_o = rx_control_q[`BIT_DRAIN_EN];
    assign rx_run_o = rx_control_q[`BIT_RUN];

    // ********
    // level flags
    // ********
    assign tx_low_o = zext(tx_chain_count_i) <
                      {16'h0000, tx_low_threshold_q};
    assign rx_high_o = zext(rx_chain_count_i) >=
                       {16'h0000, rx_high_threshold_q};

    // ********
    // link clock sampling
    // ********
    always @(posedge clock_i) begin
        if (rst_i) begin
            link_meta_q <= 1'b0;
            link_sync_q <= 1'b0;
            link_prev_q <= 1'b0;
        end else begin
            link_meta_q <= link_clk_i;
            link_sync_q <= link_meta_q;
            link_prev_q <= link_sync_q;
        end
    end
    assign link_fall = link_prev_q && !link_sync_q;

    // ********
    // transmit state machine
    // ********
    assign start_ok = (tx_io_bytes_i != 12'h000) &&
                      ({20'h0_0000, tx_io_bytes_i} >=
                       tx_start_holdoff_q);
    assign tx_idle_o = (tx_state_q == T_IDLE);

    always @(posedge clock_i) begin
        if (rst_i) begin
            tx_state_q <= T_IDLE;
            tx_done_q <= 1'b0;
            tx_byte_pop_o <= 1'b0;
            tx_active_o <= 1'b0;
        end else begin
            tx_byte_pop_o <= 1'b0;
            if (!tx_control_q[`BIT_RUN]) begin
                tx_state_q <= T_IDLE;
                tx_active_o <= 1'b0;
            end else begin
                case (tx_state_q)
                    T_IDLE: begin
                        if (tx_io_bytes_i != 12'h000)
                            tx_state_q <= T_WAIT;
                    end
                    T_WAIT: begin
                        if (start_ok) begin
                            tx_state_q <= T_SEND;
                            tx_done_q <= 1'b0;
                        end
                    end
                    T_SEND: begin
                        if (link_fall) begin
                            if (tx_io_bytes_i == 12'h000) begin
                                tx_active_o <= 1'b0;
                                tx_done_q <= 1'b1;
                                tx_state_q <= T_IDLE;
                            end else begin
                                tx_active_o <= 1'b1;
                                tx_byte_pop_o <= 1'b1;
                            end
                        end
                    end
                    default: tx_state_q <= T_IDLE;
                endcase
            end
        end
    end

    // ********
    // overrun latch and interrupt request
    // ********
    always @(posedge clock_i) begin
        if (rst_i) begin
            rx_overrun_o <= 1'b0;
            irq_o <= 1'b0;
            dma_done_o <= 1'b0;
        end else begin
            if (rx_write_i && rx_full_i)
                rx_overrun_o <= 1'b1;
            else if (overrun_clear_i)
                rx_overrun_o <= 1'b0;
            dma_done_o <= walk_done;
            irq_o <= (tx_done_q && tx_idle_o &&
                      tx_control_q[`BIT_DONE_EN]) ||
                     (tx_low_o && tx_control_q[`BIT_TX_LOW_EN]) ||
                     (rx_high_o && rx_control_q[`BIT_RX_HIGH_EN]) ||
                     (rx_overrun_o &&
                      rx_control_q[`BIT_RX_OVERRUN_EN]);
        end
    end

    // ********
    // descriptor walker
    // ********
    rx_desc_walker walker (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .start_i(walk_start_q),
        .ptr_i(walk_ptr_q),
        .rx_empty_i(rx_empty_i),
        .rx_data_i(rx_data_i),
        .pop_o(walk_pop),
        .mst_req_o(mst_req_o),
        .mst_we_o(mst_we_o),
        .mst_addr_o(mst_addr_o),
        .mst_wdata_o(mst_wdata_o),
        .mst_ack_i(mst_ack_i),
        .mst_rdata_i(mst_rdata_i),
        .mst_err_i(mst_err_i),
        .busy_o(dma_busy_o),
        .done_o(walk_done),
        .err_o(dma_err_o)
    );
endmodule // chan_dma_ctrl

// file: design/chan_dma_regs.vh
// register offsets, field positions, masks, widths and sizes for the channel
`ifndef CHAN_DMA_REGS_VH
`define CHAN_DMA_REGS_VH
`define OFS_TX_WORD_COUNT 8'h08
`define OFS_RX_DESC_START 8'h0c
`define OFS_RX_WORD_COUNT 8'h0c
`define OFS_FIFO_PORT 8'h10
`define OFS_TX_LOW_THRESHOLD 8'h14
`define OFS_RX_HIGH_THRESHOLD 8'h18
`define OFS_TX_CONTROL 8'h1c
`define OFS_TX_START_HOLDOFF 8'h2c
`define OFS_RX_CONTROL 8'h34
`define BIT_DRAIN_EN 9
`define BIT_FILL_EN 8
`define BIT_LEVEL_SEL 6
`define BIT_RX_OVERRUN_EN 4
`define BIT_RX_HIGH_EN 3
`define BIT_TX_LOW_EN 3
`define BIT_DONE_EN 2
`define BIT_RUN 0
`define PTR_EOC 0
`define PTR_DIR 1
`define CTRL_MASK 32'h0000_034d
`define RX_CTRL_MASK 32'h0000_035c
`define RST_ZERO 32'h0000_0000
`define THRESH_W 16
`define COUNT_W 24
`define IO_BYTES_W 12
`define IO_FIFO_MAX_BYTES 12'h7fc
`define DESC_WORDS 2'h3
`endif

// file: design/rx_desc_walker.v
// scatter-gather descriptor walker for the host-bound transfer
`timescale 1ns/100ps
`include "chan_dma_regs.vh"
module rx_desc_walker (
    input wire clock_i,
    input wire rst_i,
    input wire start_i,
    input wire [31:0] ptr_i,
    input wire rx_empty_i,
    input wire [31:0] rx_data_i,
    output wire pop_o,
    output reg mst_req_o,
    output reg mst_we_o,
    output reg [31:0] mst_addr_o,
    output reg [31:0] mst_wdata_o,
    input wire mst_ack_i,
    input wire [31:0] mst_rdata_i,
    input wire mst_err_i,
    output wire busy_o,
    output reg done_o,
    output reg err_o
);
    localparam S_IDLE = 2'b00;
    localparam S_FETCH = 2'b01;
    localparam S_MOVE = 2'b10;
    localparam S_NEXT = 2'b11;

    reg [1:0] state_q;
    reg [1:0] idx_q;
    reg [31:0] desc_q;
    reg [31:0] buf_q;
    reg [31:0] len_q;
    reg eoc_q;

    assign busy_o = (state_q != S_IDLE);
    assign pop_o = (state_q == S_MOVE) && !mst_req_o && !rx_empty_i &&
                   (len_q != `RST_ZERO);

    // ********
    // fetch three words, then move data, then follow
    // ********
    always @(posedge clock_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            state_q <= S_IDLE;
            idx_q <= 2'h0;
            desc_q <= `RST_ZERO;
            buf_q <= `RST_ZERO;
            len_q <= `RST_ZERO;
            eoc_q <= 1'b0;
            mst_req_o <= 1'b0;
            mst_we_o <= 1'b0;
            mst_addr_o <= `RST_ZERO;
            mst_wdata_o <= `RST_ZERO;
            err_o <= 1'b0;
        end else if (start_i && ptr_i == `RST_ZERO) begin
            state_q <= S_IDLE;
            mst_req_o <= 1'b0;
        end else if (start_i && state_q == S_IDLE) begin
            desc_q <= {ptr_i[31:2], 2'b00};
            idx_q <= 2'h0;
            eoc_q <= 1'b0;
            err_o <= 1'b0;
            state_q <= S_FETCH;
        end else begin
            case (state_q)
                S_FETCH: begin
                    if (!mst_req_o) begin
                        mst_req_o <= 1'b1;
                        mst_we_o <= 1'b0;
                        mst_addr_o <= desc_q + {28'h000_0000, idx_q, 2'b00};
                    end else if (mst_err_i) begin
                        mst_req_o <= 1'b0;
                        err_o <= 1'b1;
                        state_q <= S_IDLE;
                    end else if (mst_ack_i) begin
                        mst_req_o <= 1'b0;
                        idx_q <= idx_q + 2'h1;
                        case (idx_q)
                            2'h0: buf_q <= mst_rdata_i;
                            2'h1: len_q <= {mst_rdata_i[31:2], 2'b00};
                            default: begin
                                desc_q <= {mst_rdata_i[31:2], 2'b00};
                                eoc_q <= mst_rdata_i[`PTR_EOC];
                                if (!mst_rdata_i[`PTR_DIR])
                                    err_o <= 1'b1;
                                state_q <= mst_rdata_i[`PTR_DIR] ?
                                           S_MOVE : S_IDLE;
                            end
                        endcase
                    end
                end
                S_MOVE: begin
                    if (pop_o) begin
                        mst_req_o <= 1'b1;
                        mst_we_o <= 1'b1;
                        mst_addr_o <= buf_q;
                        mst_wdata_o <= rx_data_i;
                    end else if (mst_req_o && mst_err_i) begin
                        mst_req_o <= 1'b0;
                        err_o <= 1'b1;
                        state_q <= S_IDLE;
                    end else if (mst_req_o && mst_ack_i) begin
                        mst_req_o <= 1'b0;
                        buf_q <= buf_q + 32'h0000_0004;
                        len_q <= len_q - 32'h0000_0004;
                    end else if (!mst_req_o && len_q == `RST_ZERO) begin
                        state_q <= S_NEXT;
                    end
                end
                S_NEXT: begin
                    idx_q <= 2'h0;
                    if (eoc_q) begin
                        done_o <= 1'b1;
                        state_q <= S_IDLE;
                    end else begin
                        state_q <= S_FETCH;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
endmodule // rx_desc_walker

// file: bench/chan_dma_ctrl_asserts.sv
// port-level assertion checker for the channel dma controller
`timescale 1ns/100ps
module chan_dma_ctrl_asserts (
    input wire clock_i,
    input wire rst_i,
    input wire [7:0] reg_addr_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [31:0] reg_wdata_i,
    input wire [31:0] reg_rdata_o,
    input wire reg_rvalid_o,
    input wire mst_req_o,
    input wire [31:0] mst_addr_o,
    input wire mst_ack_i,
    input wire mst_err_i,
    input wire [23:0] tx_chain_count_i,
    input wire [23:0] rx_chain_count_i,
    input wire [11:0] tx_io_bytes_i,
    input wire tx_push_o,
    input wire [31:0] tx_push_data_o,
    input wire rx_full_i,
    input wire rx_write_i,
    input wire overrun_clear_i,
    input wire tx_active_o,
    input wire tx_idle_o,
    input wire tx_low_o,
    input wire rx_high_o,
    input wire rx_overrun_o,
    input wire dma_busy_o,
    input wire irq_o
);
    // ********
    // shadow copies of the written settings
    // ********
    reg [15:0] low_q;
    reg [15:0] high_q;
    reg [31:0] hold_q;
    reg ovr_en_q;
    wire abort_w = reg_wr_i && reg_addr_i == 8'h0c && reg_wdata_i == 0;
    always @(posedge clock_i) begin
        if (rst_i) begin
            low_q <= 16'h0000;
            high_q <= 16'h0000;
            hold_q <= 32'h0000_0000;
            ovr_en_q <= 1'b0;
        end else if (reg_wr_i) begin
            if (reg_addr_i == 8'h14) low_q <= reg_wdata_i[15:0];
            if (reg_addr_i == 8'h18) high_q <= reg_wdata_i[15:0];
            if (reg_addr_i == 8'h2c) hold_q <= reg_wdata_i;
            if (reg_addr_i == 8'h34) ovr_en_q <= reg_wdata_i[4];
        end
    end
    // ********
    // properties
    // ********
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    sequence launch_s;
        reg_wr_i && reg_addr_i == 8'h0c && reg_wdata_i != 0 && !dma_busy_o;
    endsequence
    sequence req_wait_s;
        mst_req_o && !mst_ack_i && !mst_err_i && !abort_w &&
        !$past(abort_w);
    endsequence
    AST_RVALID: assert property (reg_rvalid_o == $past(reg_rd_i))
        else $error("read answer not one cycle after strobe");
    AST_TXCNT: assert property (reg_rd_i && reg_addr_i == 8'h08 |=>
        reg_rdata_o == {8'h00, $past(tx_chain_count_i)})
        else $error("transmit count read wrong");
    AST_PUSH: assert property (reg_wr_i && reg_addr_i == 8'h10 |=>
        tx_push_o && tx_push_data_o == $past(reg_wdata_i))
        else $error("port write did not push");
    AST_LAUNCH: assert property (launch_s |-> ##3 mst_req_o
        && mst_addr_o == ($past(reg_wdata_i, 3) & 32'hffff_fffc))
        else $error("descriptor fetch not launched");
    AST_HOLD: assert property (req_wait_s |=>
        mst_req_o && $stable(mst_addr_o))
        else $error("master request dropped early");
    AST_ABORT: assert property (abort_w |-> ##[1:4] !dma_busy_o)
        else $error("abort did not stop walker");
    AST_LOW: assert property (tx_low_o ==
        (tx_chain_count_i < {8'h00, low_q}))
        else $error("transmit low flag wrong");
    AST_HIGH: assert property (rx_high_o ==
        (rx_chain_count_i >= {8'h00, high_q}))
        else $error("receive high flag wrong");
    AST_OVR: assert property (rx_full_i && rx_write_i |=> rx_overrun_o)
        else $error("overrun not latched");
    AST_IRQ: assert property (rx_overrun_o && ovr_en_q &&
        !overrun_clear_i |=> irq_o)
        else $error("enabled overrun gave no interrupt");
    AST_HOLDOFF: assert property ($rose(tx_active_o) |->
        {20'h0_0000, $past(tx_io_bytes_i)} >= $past(hold_q))
        else $error("transmit started below hold-off");
    AST_STOP: assert property (reg_wr_i && reg_addr_i == 8'h1c &&
        !reg_wdata_i[0] |-> ##[1:16] tx_idle_o)
        else $error("run clear did not idle");
endmodule // chan_dma_ctrl_asserts
bind chan_dma_ctrl chan_dma_ctrl_asserts i_chan_dma_ctrl_asserts (
    .clock_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
    .reg_rdata_o, .reg_rvalid_o, .mst_req_o, .mst_addr_o, .mst_ack_i,
    .mst_err_i, .tx_chain_count_i, .rx_chain_count_i, .tx_io_bytes_i,
    .tx_push_o, .tx_push_data_o, .rx_full_i, .rx_write_i, .overrun_clear_i,
    .tx_active_o, .tx_idle_o, .tx_low_o, .rx_high_o, .rx_overrun_o,
    .dma_busy_o, .irq_o);

// file: bench/host_mem_model.sv
// host memory answering the channel's bus master requests
`timescale 1ns/100ps
module host_mem_model (
    input wire clock_i,
    input wire rst_i,
    input wire mst_req_i,
    input wire mst_we_i,
    input wire [31:0] mst_addr_i,
    input wire [31:0] mst_wdata_i,
    input wire [3:0] delay_i,
    output reg mst_ack_o,
    output reg [31:0] mst_rdata_o,
    output reg mst_err_o
);
    reg [31:0] mem [0:255];
    reg [3:0] wait_q;
    always @(posedge clock_i) begin
        mst_ack_o <= 1'b0;
        mst_err_o <= 1'b0;
        // read data is only valid with the acknowledge
        mst_rdata_o <= ~mst_rdata_o;
        if (rst_i || !mst_req_i) begin
            wait_q <= 4'h0;
            if (rst_i) mst_rdata_o <= 32'h0000_0000;
        end else if (!mst_ack_o) begin
            if (wait_q != delay_i) begin
                wait_q <= wait_q + 4'h1;
            end else begin
                wait_q <= 4'h0;
                mst_ack_o <= 1'b1;
                if (mst_we_i) mem[mst_addr_i[9:2]] <= mst_wdata_i;
                else mst_rdata_o <= mem[mst_addr_i[9:2]];
            end
        end
    end
endmodule // host_mem_model

// file: bench/tb_top.sv
// self-checking bench for the channel dma controller
`timescale 1ns/100ps
module tb_top;
    reg clock_i = 1'b0;
    reg rst_i = 1'b1;
    reg link_clk_i = 1'b0;
    reg link_on = 1'b0;
    reg [7:0] reg_addr_i = 8'h00;
    reg reg_wr_i = 1'b0;
    reg reg_rd_i = 1'b0;
    reg [31:0] reg_wdata_i = 32'h0000_0000;
    reg [23:0] tx_chain_count_i = 24'h00_0000;
    reg [23:0] rx_chain_count_i = 24'h00_0000;
    reg [11:0] tx_io_bytes_i = 12'h000;
    reg rx_empty_i = 1'b0;
    reg [31:0] rx_data_i = 32'h0000_0000;
    reg rx_full_i = 1'b0;
    reg rx_write_i = 1'b0;
    reg overrun_clear_i = 1'b0;
    reg [3:0] delay = 4'h0;
    reg popped = 1'b0;
    reg [31:0] r;
    reg [31:0] exp_q[$];
    integer i;
    integer cycles = 0;
    integer miscompares = 0;
    integer n_compared = 0;
    wire [31:0] reg_rdata_o, mst_addr_o, mst_wdata_o, mst_rdata_i;
    wire [31:0] tx_push_data_o;
    wire reg_rvalid_o, mst_req_o, mst_we_o, mst_ack_i, mst_err_i, tx_push_o;
    wire rx_pop_o, tx_memory_fill_enable_o, tx_memory_drain_enable_o;
    wire tx_byte_pop_o, tx_active_o, tx_idle_o, tx_low_o, rx_high_o;
    wire rx_overrun_o, dma_busy_o, dma_done_o, irq_o;
    chan_dma_ctrl i_chan_dma_ctrl (.clock_i, .rst_i, .reg_addr_i, .reg_wr_i,
        .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .mst_req_o,
        .mst_we_o, .mst_addr_o, .mst_wdata_o, .mst_ack_i, .mst_rdata_i,
        .mst_err_i, .tx_chain_count_i, .rx_chain_count_i, .tx_io_bytes_i,
        .tx_push_o, .tx_push_data_o, .rx_empty_i, .rx_data_i, .rx_pop_o,
        .rx_full_i, .rx_write_i, .overrun_clear_i, .tx_memory_fill_enable_o,
        .tx_memory_drain_enable_o, .rx_memory_fill_enable_o(),
        .rx_memory_drain_enable_o(), .rx_run_o(), .link_clk_i,
        .tx_byte_pop_o, .tx_active_o, .tx_idle_o, .tx_low_o, .rx_high_o,
        .rx_overrun_o, .dma_busy_o, .dma_done_o, .dma_err_o(), .irq_o);
    host_mem_model i_host_mem_model (.clock_i, .rst_i, .mst_req_i(mst_req_o),
        .mst_we_i(mst_we_o), .mst_addr_i(mst_addr_o),
        .mst_wdata_i(mst_wdata_o), .delay_i(delay), .mst_ack_o(mst_ack_i),
        .mst_rdata_o(mst_rdata_i), .mst_err_o(mst_err_i));
    always #20 clock_i = ~clock_i;
    initial begin
        #7;
        forever #160 link_clk_i = link_on ? ~link_clk_i : link_clk_i;
    end
    // ********
    // receive fifo head advances after a pop
    // ********
    always @(posedge clock_i) popped <= rx_pop_o;
    always @(negedge clock_i) if (popped) rx_data_i <= rx_data_i + 1;
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    always @(posedge clock_i) begin
        cycles = cycles + 1;
        if (reg_rvalid_o === 1'b1) begin
            if (exp_q.size() != 0) chk(reg_rdata_o, exp_q.pop_front());
            else chk(reg_rdata_o, 32'hxxxx_xxxx);
        end
        if (cycles == 6000) begin
            miscompares = miscompares + 1;
            final_report;
        end
    end
    task final_report;
        begin
            $display("compared %0d mismatches %0d", n_compared, miscompares);
            if (miscompares == 0 && n_compared > 0) begin
                $display("bench passed");
            end else begin
                $display("bench failed");
            end
            $finish;
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge clock_i);
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            cyc(1);
            reg_addr_i = a;
            reg_wdata_i = d;
            reg_wr_i = 1'b1;
            cyc(1);
            reg_wr_i = 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [31:0] e);
        begin
            cyc(1);
            exp_q.push_back(e);
            reg_addr_i = a;
            reg_rd_i = 1'b1;
            cyc(1);
            reg_rd_i = 1'b0;
        end
    endtask
    initial begin
        r = $urandom(6);
        cyc(5);
        rst_i = 1'b0;
        r = $urandom;
        tx_chain_count_i = r[23:0];
        rx_chain_count_i = r[31:8];
        rd(8'h08, {8'h00, tx_chain_count_i});
        rd(8'h0c, {8'h00, rx_chain_count_i});
        wr(8'h1c, 32'hffff_ffff);
        rd(8'h1c, 32'h0000_034d);
        chk({tx_memory_fill_enable_o, tx_memory_drain_enable_o}, 2'b11);
        wr(8'h1c, 32'h0000_0000);
        wr(8'h14, 32'hffff_ffff);
        rd(8'h14, 32'h0000_ffff);
        wr(8'h18, 32'hffff_ffff);
        rd(8'h18, 32'h0000_ffff);
        wr(8'h2c, 32'h0000_0064);
        rd(8'h2c, 32'h0000_0064);
        rd(8'h40, 32'h0000_0000);
        cyc(2);
        $display("register test done");
        wr(8'h14, 32'h0000_0010);
        wr(8'h18, 32'h0000_0020);
        for (i = 0; i < 4; i = i + 1) begin
            tx_chain_count_i = 24'h00_000e + i[23:0];
            rx_chain_count_i = 24'h00_001e + i[23:0];
            cyc(1);
            chk(tx_low_o, i < 2);
            chk(rx_high_o, i > 1);
        end
        $display("level flag test done");
        r = $urandom;
        wr(8'h10, r);
        chk({tx_push_o, tx_push_data_o}, {1'b1, r});
        rx_data_i = ~r;
        rd(8'h10, ~r);
        chk(rx_pop_o, 1'b1);
        $display("fifo port test done");
        i_host_mem_model.mem[8'h40] = 32'h0000_0200;
        i_host_mem_model.mem[8'h41] = 32'h0000_0008;
        i_host_mem_model.mem[8'h42] = 32'h0000_0003;
        delay = 4'h2;
        cyc(2);
        r = rx_data_i;
        wr(8'h0c, 32'h0000_0102);
        for (i = 0; i < 300 && dma_done_o !== 1'b1; i = i + 1)
            @(posedge clock_i);
        cyc(1);
        chk(i < 300, 1'b1);
        chk(i_host_mem_model.mem[8'h80], r);
        chk(i_host_mem_model.mem[8'h81], r + 1);
        delay = 4'h9;
        wr(8'h0c, 32'h0000_0102);
        cyc(4);
        wr(8'h0c, 32'h0000_0000);
        cyc(4);
        chk({dma_busy_o, mst_req_o}, 2'b00);
        delay = 4'h0;
        $display("dma test done");
        wr(8'h2c, 32'h0000_0008);
        tx_io_bytes_i = 12'h004;
        wr(8'h1c, 32'h0000_0005);
        link_on = 1'b1;
        cyc(40);
        chk(tx_active_o, 1'b0);
        tx_io_bytes_i = 12'h008;
        for (i = 0; i < 60 && tx_byte_pop_o !== 1'b1; i = i + 1)
            @(posedge clock_i);
        cyc(1);
        chk({tx_active_o, i < 60}, 2'b11);
        tx_io_bytes_i = 12'h000;
        for (i = 0; i < 60 && tx_idle_o !== 1'b1; i = i + 1)
            @(posedge clock_i);
        cyc(3);
        chk(irq_o, 1'b1);
        wr(8'h1c, 32'h0000_0000);
        cyc(20);
        chk({tx_idle_o, irq_o}, 2'b10);
        link_on = 1'b0;
        $display("transmit test done");
        wr(8'h34, 32'h0000_0010);
        rx_full_i = 1'b1;
        rx_write_i = 1'b1;
        cyc(1);
        rx_write_i = 1'b0;
        rx_full_i = 1'b0;
        cyc(2);
        chk({rx_overrun_o, irq_o}, 2'b11);
        overrun_clear_i = 1'b1;
        cyc(1);
        overrun_clear_i = 1'b0;
        cyc(2);
        chk(irq_o, 1'b0);
        $display("overrun test done");
        final_report;
    end
endmodule // tb_top
